// >>> hw/tmr_timer_bank.sv
`timescale 1ns/10ps
`include "tmr_params.svh"
// What this block does
// - Ten identical independent timer channels
// - Channels 7, 8, 9 flip-flops trigger captures
// - Channel 0 starts 0-3, channel 4 starts 4-7
// - Counter, compares, captures, comparators, output flip-flop
// - Status flags set even when masked
// - Only unmasked flags raise channel interrupt
// - Reading status clears its flags
// - Four-bit prescaler makes the tap clocks
// - Prescaler run: one starts, zero stops and clears
// - Up-counter is sixteen-bit binary
// - Two-bit select: three taps or external pin
// - Counter run one counts, zero stops and clears
// - Clear-on-match clears at compare one, else free-run
// - Counter overflow raises overflow event
// - Compare zero or one match raises timer event
// - Synced slave starts with its master
module tmr_timer_bank (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [`TMR_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output wire logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output wire logic                     s_axi_wready,
  output wire logic [1:0]               s_axi_bresp,
  output wire logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`TMR_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output wire logic                     s_axi_arready,
  output wire logic [31:0]              s_axi_rdata,
  output wire logic [1:0]               s_axi_rresp,
  output wire logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     prescaler_input_clock,
  input  wire logic [`TMR_NUM_CH-1:0]   external_count_input,
  output wire logic [`TMR_NUM_CH-1:0]   timer_interrupt,
  output wire logic [`TMR_NUM_CH-1:0]   timer_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Software-visible control state
  logic [1:0]                run_reg    [`TMR_NUM_CH];
  logic [1:0]                run_next   [`TMR_NUM_CH];
  logic                      sync_reg   [`TMR_NUM_CH];
  logic                      sync_next  [`TMR_NUM_CH];
  logic [6:0]                mode_reg   [`TMR_NUM_CH];
  logic [6:0]                mode_next  [`TMR_NUM_CH];
  logic [2:0]                im_reg     [`TMR_NUM_CH];
  logic [2:0]                im_next    [`TMR_NUM_CH];
  logic [15:0]               rg0_reg    [`TMR_NUM_CH];
  logic [15:0]               rg0_next   [`TMR_NUM_CH];
  logic [15:0]               rg1_reg    [`TMR_NUM_CH];
  logic [15:0]               rg1_next   [`TMR_NUM_CH];
  logic [`TMR_NUM_CH-1:0]    irq_reg;
  logic [`TMR_NUM_CH-1:0]    irq_next;

  // Bus slave state
  logic                      aw_held_reg, aw_held_next;
  logic [`TMR_ADDR_W-1:0]    awaddr_reg,  awaddr_next;
  logic                      w_held_reg,  w_held_next;
  logic [31:0]               wdata_reg,   wdata_next;
  logic [3:0]                wstrb_reg,   wstrb_next;
  logic                      bvalid_reg,  bvalid_next;
  logic [1:0]                bresp_reg,   bresp_next;
  logic                      rvalid_reg,  rvalid_next;
  logic [31:0]               rdata_reg,   rdata_next;
  logic [1:0]                rresp_reg,   rresp_next;

  // Per-channel views
  logic [15:0]               uc_w       [`TMR_NUM_CH];
  logic [15:0]               cp0_w      [`TMR_NUM_CH];
  logic [15:0]               cp1_w      [`TMR_NUM_CH];
  logic [2:0]                st_w       [`TMR_NUM_CH];
  logic [`TMR_NUM_CH-1:0]    ff_w;
  logic [`TMR_NUM_CH-1:0]    st_clr;

  logic [3:0]                rd_ch;
  logic [3:0]                rd_idx;
  logic                      rd_ok;
  logic [31:0]               rd_word;
  logic [3:0]                wr_ch;
  logic [3:0]                wr_idx;
  logic                      wr_ok;
  logic [31:0]               wr_word;
  logic                      rd_take;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] tmr_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  // Any register slot past CP1, or a channel past the last, is unmapped
  function automatic logic tmr_addr_ok(input logic [`TMR_ADDR_W-1:0] a);
    return (a[11:10] == `TMR_TOP_ZERO) && (a[9:6] < 4'(`TMR_NUM_CH))
           && (a[5:2] <= `TMR_REG_OFS_CP1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Read decode
  assign rd_take = s_axi_arvalid & ~rvalid_reg;
  assign rd_ch   = s_axi_araddr[9:6];
  assign rd_idx  = s_axi_araddr[5:2];
  assign rd_ok   = tmr_addr_ok(s_axi_araddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_ok) begin
      if (rd_idx == `TMR_REG_OFS_RUN) begin
        rd_word = {30'h0, run_reg[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_CR) begin
        rd_word = {31'h0, sync_reg[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_MOD) begin
        rd_word = {25'h0, mode_reg[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_ST) begin
        rd_word = {29'h0, st_w[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_IM) begin
        rd_word = {29'h0, im_reg[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_UC) begin
        rd_word = {16'h0, uc_w[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_RG0) begin
        rd_word = {16'h0, rg0_reg[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_RG1) begin
        rd_word = {16'h0, rg1_reg[rd_ch]};
      end else if (rd_idx == `TMR_REG_OFS_CP0) begin
        rd_word = {16'h0, cp0_w[rd_ch]};
      end else begin
        rd_word = {16'h0, cp1_w[rd_ch]};
      end
    end
  end

  // Clear travels with the read that returns the flags
  always_comb begin
    for (int i = 0; i < `TMR_NUM_CH; i++) begin
      st_clr[i] = rd_take & rd_ok & (rd_idx == `TMR_REG_OFS_ST)
                  & (rd_ch == 4'(i));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_ch  = awaddr_reg[9:6];
  assign wr_idx = awaddr_reg[5:2];
  assign wr_ok  = tmr_addr_ok(awaddr_reg);

  always_comb begin
    wr_word = 32'h0000_0000;
    if (wr_ok) begin
      if (wr_idx == `TMR_REG_OFS_RUN) begin
        wr_word = {30'h0, run_reg[wr_ch]};
      end else if (wr_idx == `TMR_REG_OFS_CR) begin
        wr_word = {31'h0, sync_reg[wr_ch]};
      end else if (wr_idx == `TMR_REG_OFS_MOD) begin
        wr_word = {25'h0, mode_reg[wr_ch]};
      end else if (wr_idx == `TMR_REG_OFS_IM) begin
        wr_word = {29'h0, im_reg[wr_ch]};
      end else if (wr_idx == `TMR_REG_OFS_RG0) begin
        wr_word = {16'h0, rg0_reg[wr_ch]};
      end else if (wr_idx == `TMR_REG_OFS_RG1) begin
        wr_word = {16'h0, rg1_reg[wr_ch]};
      end
    end
    wr_word = tmr_merge(wr_word, wdata_reg, wstrb_reg);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next  = awaddr_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    run_next     = run_reg;
    sync_next    = sync_reg;
    mode_next    = mode_reg;
    im_next      = im_reg;
    rg0_next     = rg0_reg;
    rg1_next     = rg1_reg;

    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      if (wr_ok) begin
        if (wr_idx == `TMR_REG_OFS_RUN) begin
          run_next[wr_ch] = wr_word[1:0];
        end else if (wr_idx == `TMR_REG_OFS_CR) begin
          sync_next[wr_ch] = wr_word[0];
        end else if (wr_idx == `TMR_REG_OFS_MOD) begin
          mode_next[wr_ch] = wr_word[6:0];
        end else if (wr_idx == `TMR_REG_OFS_IM) begin
          im_next[wr_ch] = wr_word[2:0];
        end else if (wr_idx == `TMR_REG_OFS_RG0) begin
          rg0_next[wr_ch] = wr_word[15:0];
        end else if (wr_idx == `TMR_REG_OFS_RG1) begin
          rg1_next[wr_ch] = wr_word[15:0];
        end
      end
    end

    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end

    for (int i = 0; i < `TMR_NUM_CH; i++) begin
      irq_next[i] = |(st_w[i] & ~im_reg[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TMR_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `TMR_RESP_OKAY;
      irq_reg     <= '0;
      for (int i = 0; i < `TMR_NUM_CH; i++) begin
        run_reg[i]  <= `TMR_RST_RUN;
        sync_reg[i] <= 1'b0;
        mode_reg[i] <= `TMR_RST_MOD;
        im_reg[i]   <= `TMR_RST_IM;
        rg0_reg[i]  <= `TMR_RST_RG;
        rg1_reg[i]  <= `TMR_RST_RG;
      end
    end else begin
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      irq_reg     <= irq_next;
      run_reg     <= run_next;
      sync_reg    <= sync_next;
      mode_reg    <= mode_next;
      im_reg      <= im_next;
      rg0_reg     <= rg0_next;
      rg1_reg     <= rg1_next;
    end
  end

  assign s_axi_awready   = ~aw_held_reg;
  assign s_axi_wready    = ~w_held_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_arready   = ~rvalid_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign s_axi_rdata     = rdata_reg;
  assign s_axi_rresp     = rresp_reg;
  assign timer_interrupt = irq_reg;
  assign timer_out       = ff_w;

  //////////////////////////////////////////////////////////////////////////////
  // Channels; a master ignores its own sync bit
  genvar gi;
  generate
    for (gi = 0; gi < `TMR_NUM_CH; gi++) begin : g_ch
      localparam int MASTER = (gi <= `TMR_SYNC_A_LAST) ? `TMR_SYNC_A_MASTER :
                              (gi <= `TMR_SYNC_B_LAST) ? `TMR_SYNC_B_MASTER : gi;
      localparam int TRIG   = (gi <= `TMR_TRIG_CH7_LAST) ? `TMR_TRIG_CH7 :
                              (gi <= `TMR_TRIG_CH8_LAST) ? `TMR_TRIG_CH8 :
                              (gi <= `TMR_TRIG_CH9_LAST) ? `TMR_TRIG_CH9 : -1;
      tmr_ch_if chif ();

      if (MASTER != gi) begin : g_slave
        assign chif.run_prescaler = run_reg[gi][`TMR_RUN_PRESC] |
               (sync_reg[gi] & run_reg[MASTER][`TMR_RUN_PRESC]);
        assign chif.run_counter   = run_reg[gi][`TMR_RUN_COUNT] |
               (sync_reg[gi] & run_reg[MASTER][`TMR_RUN_COUNT]);
      end else begin : g_master
        assign chif.run_prescaler = run_reg[gi][`TMR_RUN_PRESC];
        assign chif.run_counter   = run_reg[gi][`TMR_RUN_COUNT];
      end

      if (TRIG >= 0) begin : g_trig
        assign chif.trig_in = ff_w[TRIG];
      end else begin : g_notrig
        assign chif.trig_in = 1'b0;
      end

      assign chif.presc_tick = prescaler_input_clock;
      assign chif.clock_sel  = tmr_pkg::tmr_src_t'(mode_reg[gi][1:0]);
      assign chif.clear_en   = mode_reg[gi][`TMR_MOD_CLR_EN];
      assign chif.cap_mode   = tmr_pkg::tmr_cap_t'(mode_reg[gi][4:3]);
      assign chif.ff_t0      = mode_reg[gi][`TMR_MOD_FF_T0];
      assign chif.ff_t1      = mode_reg[gi][`TMR_MOD_FF_T1];
      assign chif.rg0        = rg0_reg[gi];
      assign chif.rg1        = rg1_reg[gi];
      assign chif.ext_in     = external_count_input[gi];
      assign chif.st_clear   = st_clr[gi];
      assign uc_w[gi]        = chif.uc;
      assign cp0_w[gi]       = chif.cp0;
      assign cp1_w[gi]       = chif.cp1;
      assign st_w[gi]        = chif.status;
      assign ff_w[gi]        = chif.ff_out;

      tmr_channel u_ch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ch      (chif.chan)
      );
    end
  endgenerate

endmodule // tmr_timer_bank

// >>> hw/tmr_params.svh
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// Channel count and cross-channel routing
`define TMR_NUM_CH        10
`define TMR_SYNC_A_MASTER 0
`define TMR_SYNC_A_LAST   3
`define TMR_SYNC_B_MASTER 4
`define TMR_SYNC_B_LAST   7
`define TMR_TRIG_CH7      7
`define TMR_TRIG_CH7_LAST 1
`define TMR_TRIG_CH8      8
`define TMR_TRIG_CH8_LAST 4
`define TMR_TRIG_CH9      9
`define TMR_TRIG_CH9_LAST 6

// Address layout: one 64-byte window per channel
`define TMR_ADDR_W        12
`define TMR_TOP_ZERO      2'h0
`define TMR_REG_OFS_RUN   4'h0
`define TMR_REG_OFS_CR    4'h1
`define TMR_REG_OFS_MOD   4'h2
`define TMR_REG_OFS_ST    4'h3
`define TMR_REG_OFS_IM    4'h4
`define TMR_REG_OFS_UC    4'h5
`define TMR_REG_OFS_RG0   4'h6
`define TMR_REG_OFS_RG1   4'h7
`define TMR_REG_OFS_CP0   4'h8
`define TMR_REG_OFS_CP1   4'h9

// Field positions
`define TMR_RUN_PRESC     0
`define TMR_RUN_COUNT     1
`define TMR_MOD_CLR_EN    2
`define TMR_MOD_FF_T0     5
`define TMR_MOD_FF_T1     6
`define TMR_ST_MATCH0     0
`define TMR_ST_MATCH1     1
`define TMR_ST_OVF        2

// Reset values and counter constants
`define TMR_RST_RUN       2'h0
`define TMR_RST_MOD       7'h00
`define TMR_RST_IM        3'h0
`define TMR_RST_RG        16'h0000
`define TMR_UC_MAX        16'hFFFF
`define TMR_PSC_DIV4_LAST 2'h3
`define TMR_PSC_DIV16_LAST 4'hF

// Bus answers
`define TMR_RESP_OKAY     2'h0
`define TMR_RESP_SLVERR   2'h2

`endif

// >>> hw/tmr_pkg.sv
package tmr_pkg;

  typedef enum logic [1:0] {
    tmr_src_div1,
    tmr_src_div4,
    tmr_src_div16,
    tmr_src_ext
  } tmr_src_t;

  typedef enum logic [1:0] {
    tmr_cap_off,
    tmr_cap_trig,
    tmr_cap_ext,
    tmr_cap_rsvd
  } tmr_cap_t;

endpackage

// >>> hw/tmr_ch_if.sv
`timescale 1ns/10ps
interface tmr_ch_if;
  logic                presc_tick;
  logic                run_prescaler;
  logic                run_counter;
  tmr_pkg::tmr_src_t   clock_sel;
  logic                clear_en;
  tmr_pkg::tmr_cap_t   cap_mode;
  logic                ff_t0;
  logic                ff_t1;
  logic [15:0]         rg0;
  logic [15:0]         rg1;
  logic                trig_in;
  logic                ext_in;
  logic                st_clear;
  logic [15:0]         uc;
  logic [15:0]         cp0;
  logic [15:0]         cp1;
  logic [2:0]          status;
  logic                ff_out;

  modport top (
    output presc_tick, run_prescaler, run_counter, clock_sel, clear_en, cap_mode,
    output ff_t0, ff_t1, rg0, rg1, trig_in, ext_in, st_clear,
    input  uc, cp0, cp1, status, ff_out
  );

  modport chan (
    input  presc_tick, run_prescaler, run_counter, clock_sel, clear_en, cap_mode,
    input  ff_t0, ff_t1, rg0, rg1, trig_in, ext_in, st_clear,
    output uc, cp0, cp1, status, ff_out
  );
endinterface

// >>> hw/tmr_channel.sv
`timescale 1ns/10ps
`include "tmr_params.svh"
module tmr_channel (
  input wire logic aclk,
  input wire logic aresetn,
  tmr_ch_if.chan   ch
);

  logic [3:0]  psc_reg,       psc_next;
  logic [15:0] uc_reg,        uc_next;
  logic [15:0] cp0_reg,       cp0_next;
  logic [15:0] cp1_reg,       cp1_next;
  logic [2:0]  st_reg,        st_next;
  logic        ff_reg,        ff_next;
  logic        ext_meta_reg,  ext_meta_next;
  logic        ext_sync_reg,  ext_sync_next;
  logic        ext_prev_reg,  ext_prev_next;
  logic        trig_prev_reg, trig_prev_next;
  logic        tap1;
  logic        tap4;
  logic        tap16;
  logic        ext_rise;
  logic        ext_fall;
  logic        src_tick;
  logic        hit0;
  logic        hit1;
  logic        wrap;
  logic        clr_hit;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ext_meta_next  = ch.ext_in;
    ext_sync_next  = ext_meta_reg;
    ext_prev_next  = ext_sync_reg;
    trig_prev_next = ch.trig_in;
    ext_rise       = ext_sync_reg & ~ext_prev_reg;
    ext_fall       = ~ext_sync_reg & ext_prev_reg;

    // Taps derive from one 4-bit count so all three stay phase aligned
    tap1  = ch.run_prescaler & ch.presc_tick;
    tap4  = tap1 & (psc_reg[1:0] == `TMR_PSC_DIV4_LAST);
    tap16 = tap1 & (psc_reg == `TMR_PSC_DIV16_LAST);
    if (!ch.run_prescaler) begin
      psc_next = 4'h0;
    end else if (ch.presc_tick) begin
      psc_next = psc_reg + 4'h1;
    end else begin
      psc_next = psc_reg;
    end

    case (ch.clock_sel)
      tmr_pkg::tmr_src_div1:  src_tick = tap1;
      tmr_pkg::tmr_src_div4:  src_tick = tap4;
      tmr_pkg::tmr_src_div16: src_tick = tap16;
      default:                src_tick = ext_rise;
    endcase

    hit0    = ch.run_counter & src_tick & (uc_reg == ch.rg0);
    hit1    = ch.run_counter & src_tick & (uc_reg == ch.rg1);
    clr_hit = hit1 & ch.clear_en;
    wrap    = ch.run_counter & src_tick & (uc_reg == `TMR_UC_MAX) & ~clr_hit;

    if (!ch.run_counter) begin
      uc_next = 16'h0000;
    end else if (clr_hit) begin
      uc_next = 16'h0000;
    end else if (src_tick) begin
      uc_next = uc_reg + 16'h0001;
    end else begin
      uc_next = uc_reg;
    end

    cp0_next = cp0_reg;
    cp1_next = cp1_reg;
    case (ch.cap_mode)
      tmr_pkg::tmr_cap_trig: begin
        if (ch.trig_in && !trig_prev_reg) cp0_next = uc_reg;
        if (!ch.trig_in && trig_prev_reg) cp1_next = uc_reg;
      end
      tmr_pkg::tmr_cap_ext: begin
        if (ext_rise) cp0_next = uc_reg;
        if (ext_fall) cp1_next = uc_reg;
      end
      default: begin
        cp0_next = cp0_reg;
      end
    endcase

    ff_next = ff_reg ^ (hit0 & ch.ff_t0) ^ (hit1 & ch.ff_t1);

    // An event in the same cycle as the clearing read survives
    st_next = (st_reg & ~{3{ch.st_clear}}) | {wrap, hit1, hit0};
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_reg       <= 4'h0;
      uc_reg        <= 16'h0000;
      cp0_reg       <= 16'h0000;
      cp1_reg       <= 16'h0000;
      st_reg        <= 3'h0;
      ff_reg        <= 1'b0;
      ext_meta_reg  <= 1'b0;
      ext_sync_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      psc_reg       <= psc_next;
      uc_reg        <= uc_next;
      cp0_reg       <= cp0_next;
      cp1_reg       <= cp1_next;
      st_reg        <= st_next;
      ff_reg        <= ff_next;
      ext_meta_reg  <= ext_meta_next;
      ext_sync_reg  <= ext_sync_next;
      ext_prev_reg  <= ext_prev_next;
      trig_prev_reg <= trig_prev_next;
    end
  end

  assign ch.uc     = uc_reg;
  assign ch.cp0    = cp0_reg;
  assign ch.cp1    = cp1_reg;
  assign ch.status = st_reg;
  assign ch.ff_out = ff_reg;

endmodule // tmr_channel

// >>> dv/tmr_timer_bank_sva.sv
`timescale 1ns/10ps
module tmr_timer_bank_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [9:0] timer_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_done;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> s_wr_done) else $error("write answer late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
  a_irq_quiet: assert property ($rose(aresetn) |-> timer_interrupt == 10'h000)
    else $error("irq after reset");
endmodule // tmr_timer_bank_sva
bind tmr_timer_bank tmr_timer_bank_sva tmr_timer_bank_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_interrupt(timer_interrupt));

// >>> dv/tmr_timer_bank_tb.sv
`timescale 1ns/10ps
`include "tmr_params.svh"
module tmr_timer_bank_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        pic = 1'b0;
  logic [9:0]  ext = 10'h000;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [9:0]  irq, tout;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          failures = 0;
  int          checked = 0;
  tmr_timer_bank tmr_timer_bank_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .prescaler_input_clock(pic), .external_count_input(ext),
    .timer_interrupt(irq), .timer_out(tout));
  initial begin
    forever #50 aclk = ~aclk;
  end
  //////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Response ready rides along with the request, so no answer is ever missed
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rg(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Input held high n cycles gives exactly n prescaler input pulses
  // One fixed input rate for the whole run, so no gear change mid-count
  task automatic tick(input int n);
    @(posedge aclk);
    pic <= 1'b1;
    repeat (n) @(posedge aclk);
    pic <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////
  task automatic t_basic;
    rg(12'h008);
    chk("mod reset", 32'h0, rd);
    wr(12'h028, 32'h5A);
    chk("bresp", 32'(`TMR_RESP_SLVERR), 32'(rs));
    rg(12'h028);
    chk("rresp", 32'(`TMR_RESP_SLVERR), 32'(rs));
  endtask
  task automatic t_sources;
    logic [31:0] e[4];
    e = '{32'd32, 32'd8, 32'd2, 32'd5};
    for (int s = 0; s < 4; s++) begin
      wr(12'h000, 32'h0);
      // External source also captures pin edges: rise to CP0, fall to CP1
      wr(12'h008, (s == 3) ? 32'h13 : 32'(s));
      wr(12'h000, 32'h3);
      if (s < 3) tick(32);
      else repeat (5) begin
        ext[0] <= 1'b1;
        repeat (4) @(posedge aclk);
        ext[0] <= 1'b0;
        repeat (4) @(posedge aclk);
      end
      rg(12'h014);
      chk("count", e[s], rd);
      if (s == 3) begin
        rg(12'h020);
        chk("cap rise", 32'h4, rd);
        rg(12'h024);
        chk("cap fall", 32'h5, rd);
      end
    end
    wr(12'h000, 32'h1);
    rg(12'h014);
    chk("stopped", 32'h0, rd);
  endtask
  task automatic t_match;
    wr(12'h000, 32'h0);
    rg(12'h00C);
    wr(12'h01C, 32'h4);
    wr(12'h010, 32'h7);
    wr(12'h008, 32'h4);
    wr(12'h000, 32'h3);
    tick(12);
    rg(12'h014);
    chk("clear", 32'h2, rd);
    chk("irq masked", 32'h0, 32'(irq[0]));
    rg(12'h00C);
    chk("status", 32'h3, rd);
    rg(12'h00C);
    chk("cleared", 32'h0, rd);
    wr(12'h010, 32'h5);
    tick(5);
    chk("irq", 32'h1, 32'(irq[0]));
    wr(12'h000, 32'h0);
    rg(12'h00C);
    wr(12'h008, 32'h0);
    wr(12'h000, 32'h3);
    tick(65536);
    rg(12'h00C);
    chk("overflow", 32'h7, rd);
  endtask
  task automatic t_sync;
    wr(12'h000, 32'h0);
    wr(12'h044, 32'h1);
    wr(12'h000, 32'h3);
    tick(3);
    rg(12'h054);
    chk("slave", 32'h3, rd);
  endtask
  // Channel 7 toggles its flip-flop on compare 1; channel 0 captures that edge
  task automatic t_trig;
    wr(12'h000, 32'h0);
    wr(12'h008, 32'h08);
    wr(12'h000, 32'h3);
    wr(12'h1DC, 32'h2);
    wr(12'h1C8, 32'h44);
    wr(12'h1C0, 32'h3);
    tick(4);
    chk("ff out", 32'h080, 32'(tout));
    rg(12'h020);
    chk("capture", 32'h3, rd);
  endtask
  //////////////////////////////////////////////////
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_basic();
    t_sources();
    t_match();
    t_sync();
    t_trig();
    conclude();
  end
  initial begin
    repeat (90000) @(posedge aclk);
    failures++;
    conclude();
  end
endmodule // tmr_timer_bank_tb
